/* File: sim/flash_dev_model.sv */
// Behavioural flash die answering the controller's pins.
// Assumes one host on the pins; only a 256-word array window is kept.
module flash_dev_model #(
    parameter int          ACC_NS  = 150,
    parameter int          BUSY_NS = 3000,
    parameter logic [15:0] ID_CODE = 16'hc3a5  // Arbitrary value
) (
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        reset_n_i,
    input  wire logic [21:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        accel_i,
    input  wire logic        word_i,
    output wire logic [15:0] dq_o,
    output logic             ready_busy_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [256];
    logic [15:0] held = 16'h0000;
    logic        bypass = 1'b0, pend = 1'b0, id_mode = 1'b0, hv = 1'b0;
    wire         rd_en = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
    // ----------------
    // Read and command paths
    // ----------------
    initial begin
        ready_busy_n_o = 1'b1;
        for (int i = 0; i < 256; i++) mem[i] = {i[7:0], ~i[7:0]};
    end
    always @* if (rd_en) held = id_mode ? ID_CODE : mem[addr_i[7:0]];
    // Released bus shows the inverse, so a capture before access time fails
    assign #(ACC_NS) dq_o = rd_en ? held : ~held;
    // Voltage seen mid-strobe, as it may fall on the same edge as the strobe
    always @* if (!we_n_i && accel_i) hv = 1'b1;
    always @(posedge we_n_i) begin
        if (!ce_n_i && reset_n_i) begin
            if (pend) begin
                mem[addr_i[7:0]] = word_i ? dq_i : {8'h00, dq_i[7:0]};
                pend = 1'b0;
                ready_busy_n_o = 1'b0;
                ready_busy_n_o <= #(BUSY_NS) 1'b1;
            end else if (dq_i[7:0] == 8'ha0) pend = bypass || hv;
            else if (dq_i[7:0] == 8'h20) bypass = 1'b1;
            else if (dq_i[7:0] == 8'h30) for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
            else if (dq_i[7:0] == 8'h90 || dq_i[7:0] == 8'hf0) id_mode = !dq_i[6];
        end
        hv = 1'b0;
    end
    always @(negedge reset_n_i) {bypass, pend, id_mode} = 3'b000;
endmodule

/* File: sim/flash_host_chk.sv */
// Checker of the flash host controller's pin sequencing.
// Sees only the controller's ports; bound to every instance.
module flash_host_chk (
    input logic clk_sys_i,
    input logic rst_n_i,
    input logic flash_ce_n_o,
    input logic flash_oe_n_o,
    input logic flash_we_n_o,
    input logic flash_reset_n_o,
    input logic flash_dq_oe_o,
    input logic protect_accelerate_pin_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------
    // Pin sequencing
    // ----------------
    rd_levels_a: assert property (!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o)
        else $error("read strobes wrong");
    wr_levels_a: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o)
        else $error("write strobes wrong");
    wr_hold_a: assert property ($rose(flash_we_n_o) |-> !flash_ce_n_o && flash_dq_oe_o)
        else $error("no hold after write");
    acc_write_a: assert property (protect_accelerate_pin_o |-> !flash_we_n_o)
        else $error("high voltage outside write");
    rd_width_a: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*2])
        else $error("read shorter than access");
    rst_quiet_a: assert property (!flash_reset_n_o |-> flash_ce_n_o && flash_we_n_o)
        else $error("strobe during reset");
    rst_width_a: assert property ($fell(flash_reset_n_o) |-> !flash_reset_n_o [*6])
        else $error("reset pulse short");
    rst_recover_a: assert property ($rose(flash_reset_n_o) |-> flash_oe_n_o [*2])
        else $error("read before recovery");
    rd_seen_c: cover property ($fell(flash_oe_n_o));
    acc_seen_c: cover property (protect_accelerate_pin_o);
    rst_seen_c: cover property ($fell(flash_reset_n_o));
endmodule
bind flash_host_ctrl flash_host_chk chk_u (
    .clk_sys_i, .rst_n_i, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o, .flash_dq_oe_o,
    .protect_accelerate_pin_o);

/* File: sim/tb_flash_bus_operation_control.sv */
// Bench: APB traffic into the flash host controller, device model on its pins.
// Assumes the map header on the include path and a 10 MHz clock.
`include "flash_host_map.vh"
module tb_flash_bus_operation_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ID = 16'h5a3c;  // Arbitrary value
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000, q, r = 32'h00014cf8;
    logic [21:0] a;
    int          n_mismatch = 0, tests_run = 0;
    wire  [31:0] prdata_o;
    wire  [21:0] fa;
    wire  [15:0] fd, md, dq;
    wire         pready_o, ce_n, oe_n, we_n, rs_n, doe, acc, wd, rdy;
    assign dq = doe ? fd : md;
    always #50 clk_sys_i = ~clk_sys_i;
    flash_host_ctrl dut_u (
        .clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o(), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_reset_n_o(rs_n),
        .flash_addr_o(fa), .flash_dq_o(fd), .flash_dq_oe_o(doe), .flash_dq_i(dq), .ready_busy_n_out_i(rdy),
        .protect_accelerate_pin_o(acc), .byte_word_select_o(wd));
    flash_dev_model #(.ID_CODE(ID)) dev_u (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(rs_n),
        .addr_i(fa), .dq_i(dq), .accel_i(acc), .word_i(wd), .dq_o(md), .ready_busy_n_o(rdy));
    // ----------------
    // Bus tasks and expectations
    // ----------------
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done(input int bad);
        n_mismatch += bad;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Idle edge first, so a release and the next request never share a step
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n = 0;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do @(posedge clk_sys_i); while (pready_o !== 1'b1 && ++n < 20);
        q = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) test_done(1);
    endtask
    task automatic op(input logic [31:0] c);
        int n = 0;
        apb(1'b1, `REG_CTRL, c);
        do apb(1'b0, `REG_STATUS, 32'h0); while (q[`STAT_DONE] !== 1'b1 && ++n < 400);
        if (n >= 400) test_done(1);
    endtask
    task automatic fcmd(input logic [21:0] ad, input logic [15:0] d, input logic [31:0] m);
        apb(1'b1, `REG_ADDR, {10'h000, ad});
        apb(1'b1, `REG_WDATA, {16'h0000, d});
        op(m | 32'h3);
    endtask
    task automatic prog(input logic [21:0] ad, input logic [15:0] d, input logic [31:0] m);
        fcmd(ad, 16'h00a0, m);
        fcmd(ad, d, m);
    endtask
    task automatic fread(input logic [21:0] ad, input logic [15:0] e);
        apb(1'b1, `REG_ADDR, {10'h000, ad});
        op(32'h1);
        apb(1'b0, `REG_RDATA, 32'h0);
        check("flash data", {16'h0000, e}, {16'h0000, q[15:0]});
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        apb(1'b0, `REG_CTRL, 32'h0);
        check("ctrl reset", `CTRL_RST, q);
        apb(1'b0, `REG_STATUS, 32'h0);
        check("status reset", 32'h2, q & 32'h7);
        apb(1'b1, 12'h01c, 32'hffffffff);
        apb(1'b0, 12'h01c, 32'h0);
        check("unmapped", 32'h0, q);
        for (int i = 0; i < 8; i++) begin
            r = nxt(r);
            apb(1'b1, `REG_TIMING, {30'h0, r[31:30]});
            fread(r[21:0], {r[7:0], ~r[7:0]});
        end
        apb(1'b0, `REG_TIMING, 32'h0);
        check("timing", {30'h0, r[31:30]}, q);
        r = nxt(r);
        a = r[21:0];
        fcmd(a, 16'h0020, 32'h0);
        prog(a, r[31:16], 32'h0);
        fread(a, r[31:16]);
        prog(a, 16'h9c5e, 32'h10);
        fread(a, 16'h005e);
        // Reset lands while the device is still busy programming
        prog(a, 16'h1234, 32'h0);
        op(32'h5);
        apb(1'b0, `REG_STATUS, 32'h0);
        check("ready after reset", 32'h2, q & 32'h2);
        prog(22'h2a55c3, 16'h1234, 32'h0);
        fread(22'h2a55c3, 16'hc33c);
        prog(22'h2a55c3, 16'h1234, 32'h8);
        fread(22'h2a55c3, 16'h1234);
        fcmd(a, 16'h0090, 32'h0);
        fread(a, ID);
        fcmd(a, 16'h00f0, 32'h0);
        fread(a, 16'h1234);
        fcmd(a, 16'h0030, 32'h0);
        fread(a, 16'hffff);
        test_done(0);
    end
endmodule

/* File: src/flash_host_ctrl.v */
// Host controller driving an asynchronous NOR flash through its pins.
// Assumes an APB master on the system clock and synchronous pin inputs.
// Notes on behaviour
// RQ1: Reads drive chip select and output enable low, write enable high.
// RQ2: Device reads array after power-up and reset; no command needed.
// RQ3: Each bank stays in read mode until a command changes it.
// RQ4: Commands drive write enable and chip select low, output enable high.
// RQ5: Shortened mode programs with two write cycles instead of four.
// RQ6: Device erases one sector, several sectors or whole chip.
// RQ7: Four banks chosen by top address bits; sectors by sector bits.
// RQ8: High voltage on protect pin gives shortened, unprotected, faster programming.
// RQ9: Host uses two-cycle program under high voltage; never floats the pin.
// RQ10: Identifier sequence makes reads return register codes with read timing.
// RQ11: One bank reads with zero latency while another programs or erases.
// RQ12: Erase may be suspended to access the bank outside that sector.
// RQ13: Chip select and reset high put device in standby, outputs tristated.
// RQ14: After standby, first read needs the chip-select access time.
// RQ15: Deselecting during program or erase lets it run to completion.
// RQ16: Stable addresses trigger automatic sleep with latched output data.
// RQ17: Reset pulse of minimum width aborts, tristates, returns to read mode.
// RQ18: Host restarts interrupted program or erase once device is ready; the controller only sets done and leaves the restart to software.
// RQ19: Reset during program or erase holds ready/busy low until done.
// RQ20: Reset while idle completes within the non-embedded ready time.
// RQ21: Host waits the recovery time after reset before reading.
// RQ22: Byte/word select level decides byte or word program data.
`include "flash_host_map.vh"
module flash_host_ctrl (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    output reg         flash_ce_n_o,
    output reg         flash_oe_n_o,
    output reg         flash_we_n_o,
    output reg         flash_reset_n_o,
    output reg  [21:0] flash_addr_o,
    output reg  [15:0] flash_dq_o,
    output reg         flash_dq_oe_o,
    input  wire [15:0] flash_dq_i,
    input  wire        ready_busy_n_out_i,
    output reg         protect_accelerate_pin_o,
    output reg         byte_word_select_o
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam ST_IDLE  = 3'h0;
    localparam ST_READ  = 3'h1;
    localparam ST_WRITE = 3'h2;
    localparam ST_WHOLD = 3'h3;
    localparam ST_RST   = 3'h4;
    localparam ST_RREC  = 3'h5;
    localparam ST_RWAIT = 3'h6;

    // Cycle counts cut to the timer width; none of them reaches 4096
    localparam integer ACC_I   = `ACC_CYC;
    localparam integer WP_I    = `WP_CYC;
    localparam integer RP_I    = `RP_CYC;
    localparam integer RH_I    = `RH_CYC;
    localparam integer READY_I = `READY_CYC;
    localparam [11:0]  ACC_CNT   = ACC_I[11:0];
    localparam [11:0]  WP_CNT    = WP_I[11:0];
    localparam [11:0]  RP_CNT    = RP_I[11:0];
    localparam [11:0]  RH_CNT    = RH_I[11:0];
    localparam [11:0]  READY_CNT = READY_I[11:0];

    reg  [2:0]  state;
    reg  [1:0]  cmd;
    reg         accel;
    reg         byte_mode;
    reg  [21:0] addr_reg;
    reg  [15:0] wdata_reg;
    reg  [15:0] rdata_reg;
    reg         done;
    reg  [11:0] extra_wait;
    reg         tmr_load;
    reg  [11:0] tmr_count;
    reg  [31:0] rd_mux;
    wire        tmr_expired;
    wire        wr_en;
    wire        go;

    function sel_reg;
        input [11:0] a;
        input [11:0] off;
        begin
            sel_reg = (a == off);
        end
    endfunction

    pulse_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .load_i    (tmr_load),
        .count_i   (tmr_count),
        .expired_o (tmr_expired)
    );

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;
    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign go        = wr_en && sel_reg(paddr_i, `REG_CTRL) && pwdata_i[`CTRL_GO] && (state == ST_IDLE);
    assign prdata_o  = rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        if (sel_reg(paddr_i, `REG_CTRL)) begin
            rd_mux = {26'h0000000, 1'b0, byte_mode, accel, cmd, 1'b0};
        end else if (sel_reg(paddr_i, `REG_ADDR)) begin
            rd_mux = {10'h000, addr_reg};
        end else if (sel_reg(paddr_i, `REG_WDATA)) begin
            rd_mux = {16'h0000, wdata_reg};
        end else if (sel_reg(paddr_i, `REG_RDATA)) begin
            rd_mux = {16'h0000, rdata_reg};
        end else if (sel_reg(paddr_i, `REG_STATUS)) begin
            rd_mux = {29'h00000000, done, ready_busy_n_out_i, state != ST_IDLE};
        end else if (sel_reg(paddr_i, `REG_TIMING)) begin
            rd_mux = {20'h00000, extra_wait};
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd        <= 2'h0;
            accel      <= 1'b0;
            byte_mode  <= 1'b0;
            addr_reg   <= 22'h000000;
            wdata_reg  <= 16'h0000;
            extra_wait <= 12'h000;
        end else if (wr_en) begin
            if (sel_reg(paddr_i, `REG_CTRL) && state == ST_IDLE) begin
                cmd       <= pwdata_i[`CTRL_CMD_MSB:`CTRL_CMD_LSB];
                accel     <= pwdata_i[`CTRL_ACCEL];
                byte_mode <= pwdata_i[`CTRL_BYTE];
            end
            if (sel_reg(paddr_i, `REG_ADDR)) begin
                addr_reg <= pwdata_i[21:0];
            end
            if (sel_reg(paddr_i, `REG_WDATA)) begin
                wdata_reg <= pwdata_i[15:0];
            end
            if (sel_reg(paddr_i, `REG_TIMING)) begin
                extra_wait <= pwdata_i[11:0];
            end
        end
    end

    // ----------------------------------------
    // Pin sequencer
    // ----------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state                    <= ST_IDLE;
            flash_ce_n_o             <= 1'b1;
            flash_oe_n_o             <= 1'b1;
            flash_we_n_o             <= 1'b1;
            flash_reset_n_o          <= 1'b0;
            flash_addr_o             <= 22'h000000;
            flash_dq_o               <= 16'h0000;
            flash_dq_oe_o            <= 1'b0;
            protect_accelerate_pin_o <= 1'b0;
            byte_word_select_o       <= 1'b0;
            rdata_reg                <= 16'h0000;
            done                     <= 1'b0;
            tmr_load                 <= 1'b0;
            tmr_count                <= 12'h000;
        end else begin
            tmr_load <= 1'b0;
            // Accelerate level driven only while its command runs, never floated
            // Drops on the edge that raises write enable, so never outside the strobe
            protect_accelerate_pin_o <= accel && state == ST_WRITE && !tmr_expired; // RQ9
            byte_word_select_o       <= !byte_mode; // RQ22
            case (state)
                ST_IDLE: begin
                    // Idle: deselected, so the device sits in standby
                    flash_ce_n_o    <= 1'b1; // RQ13
                    flash_oe_n_o    <= 1'b1;
                    flash_we_n_o    <= 1'b1;
                    flash_dq_oe_o   <= 1'b0;
                    flash_reset_n_o <= 1'b1;
                    if (go) begin
                        done         <= 1'b0;
                        flash_addr_o <= addr_reg;
                        tmr_load     <= 1'b1;
                        if (pwdata_i[`CTRL_CMD_MSB:`CTRL_CMD_LSB] == `CMD_READ) begin
                            flash_ce_n_o <= 1'b0; // RQ1
                            flash_oe_n_o <= 1'b0; // RQ1
                            // Full chip-select access time, since we leave standby
                            tmr_count    <= ACC_CNT + extra_wait; // RQ14
                            state        <= ST_READ;
                        end else if (pwdata_i[`CTRL_CMD_MSB:`CTRL_CMD_LSB] == `CMD_WRITE) begin
                            flash_ce_n_o  <= 1'b0; // RQ4
                            flash_we_n_o  <= 1'b0; // RQ4
                            flash_dq_o    <= wdata_reg;
                            flash_dq_oe_o <= 1'b1;
                            tmr_count     <= WP_CNT + extra_wait;
                            state         <= ST_WRITE;
                        end else begin
                            flash_reset_n_o <= 1'b0; // RQ17
                            tmr_count       <= RP_CNT;
                            state           <= ST_RST;
                        end
                    end
                end
                ST_READ: begin
                    if (tmr_expired) begin
                        rdata_reg    <= flash_dq_i;
                        flash_oe_n_o <= 1'b1;
                        flash_ce_n_o <= 1'b1;
                        done         <= 1'b1;
                        state        <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (tmr_expired) begin
                        // Data held one cycle past the rising write enable
                        flash_we_n_o <= 1'b1;
                        state        <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    flash_ce_n_o  <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    done          <= 1'b1;
                    state         <= ST_IDLE;
                end
                ST_RST: begin
                    if (tmr_expired) begin
                        flash_reset_n_o <= 1'b1;
                        tmr_load        <= 1'b1;
                        tmr_count       <= RH_CNT;
                        state           <= ST_RREC;
                    end
                end
                ST_RREC: begin
                    // Recovery before any read
                    if (tmr_expired) begin // RQ21
                        tmr_load  <= 1'b1;
                        tmr_count <= READY_CNT;
                        state     <= ST_RWAIT;
                    end
                end
                ST_RWAIT: begin
                    // Ready/busy high or ready time elapsed; software may then restart
                    if (ready_busy_n_out_i || tmr_expired) begin // RQ18
                        done  <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: src/flash_host_map.vh */
// Constants for the flash bus-operation host controller.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_CTRL        12'h000
`define REG_ADDR        12'h004
`define REG_WDATA       12'h008
`define REG_RDATA       12'h00c
`define REG_STATUS      12'h010
`define REG_TIMING      12'h014
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_GO         0
`define CTRL_CMD_LSB    1
`define CTRL_CMD_MSB    2
`define CTRL_ACCEL      3
`define CTRL_BYTE       4
`define CTRL_RESET      5
// Commands
`define CMD_READ        2'h0
`define CMD_WRITE       2'h1
`define CMD_RESET       2'h2
// ----------------------------------------
// Status fields
// ----------------------------------------
`define STAT_BUSY       0
`define STAT_RDY        1
`define STAT_DONE       2
// ----------------------------------------
// Timing (ns) and derived cycles at 100 ns
// ----------------------------------------
`define CLK_NS          100
`define T_ACC_NS        70
`define T_WP_NS         35
`define T_RP_NS         500
`define T_RH_NS         50
`define T_READY_NS      20000
`define ACC_CYC         ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC          ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define RP_CYC          ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define RH_CYC          ((`T_RH_NS + `CLK_NS - 1) / `CLK_NS)
`define READY_CYC       ((`T_READY_NS + `CLK_NS - 1) / `CLK_NS)
`define CTRL_RST        32'h00000000
`endif

/* File: src/pulse_timer.v */
// Down-counter timing one pin phase in system clock cycles.
// Assumes load and count are driven from the same clock.
module pulse_timer (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        load_i,
    input  wire [11:0] count_i,
    output wire        expired_o
);
    reg [11:0] remain;
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remain <= 12'h000;
        end else if (load_i) begin
            remain <= count_i;
        end else if (remain != 12'h000) begin
            remain <= remain - 12'h001;
        end
    end
    assign expired_o = (remain == 12'h000) && !load_i;
endmodule
